/* lhc_checker.sv */
// Link protocol checks for the LCD host command link
`timescale 1ns/1ps
module lhc_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Link
  input wire logic        cs_n,
  input wire logic        dc,
  input wire logic        rw_wr_n,
  input wire logic        e_rd_n,
  input wire logic        hardware_reset_n,
  input wire logic [2:0]  interface_select,
  input wire logic [15:0] h_d,
  input wire logic        h_d_oe_n,
  input wire logic [7:0]  dv_d,
  input wire logic        dv_d_oe_n,
  input wire logic [15:0] d
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [5:0] low_q;
  wire        p6800 = interface_select[1:0] == 2'h3;
  wire        p8080 = interface_select[1:0] == 2'h1;
  wire        ser   = !interface_select[0];
  // Saturates so a stuck reset pin cannot wrap back to a short count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_q <= 6'h00;
    end else if (hardware_reset_n) begin
      low_q <= 6'h00;
    end else if (low_q != 6'h3f) begin
      low_q <= low_q + 6'h01;
    end
  end
  sequence wr_pulse_s;
    (!rw_wr_n && !cs_n) [*8] ##1 rw_wr_n;
  endsequence
  sequence rd_pulse_s;
    (!e_rd_n && !cs_n) [*8] ##1 e_rd_n;
  endsequence
  sequence en_pulse_s;
    (e_rd_n && !cs_n) [*8] ##1 !e_rd_n;
  endsequence
  a_wr_strobe_sel: assert property (
    $fell(rw_wr_n) && p8080 |-> wr_pulse_s)
    else $error("write strobe length or select wrong");
  a_rd_strobe_sel: assert property (
    $fell(e_rd_n) && p8080 |-> rd_pulse_s)
    else $error("read strobe length or select wrong");
  // After reset the idle enable level settles; only selected rises count
  a_enable_latch: assert property (
    $rose(e_rd_n) && p6800 && !cs_n |-> en_pulse_s)
    else $error("enable pulse length or select wrong");
  a_read_dir: assert property (p6800 && !dv_d_oe_n |-> rw_wr_n)
    else $error("device drove bus outside a read");
  a_write_dir: assert property (
    p6800 && e_rd_n && !rw_wr_n |-> dv_d_oe_n)
    else $error("device drove bus during a write");
  a_drive_selected: assert property (!dv_d_oe_n |-> !cs_n && !ser)
    else $error("device drove bus unselected or serial");
  a_no_contention: assert property (!(!dv_d_oe_n && !h_d_oe_n))
    else $error("both ends drive the data bus");
  a_sda_stable: assert property (
    ser && d[6] && $past(d[6]) |-> $stable(d[7]))
    else $error("serial data moved while clock high");
  a_sck_idle: assert property (ser && cs_n |-> !d[6])
    else $error("serial clock active outside a frame");
  a_reset_len: assert property (
    $rose(hardware_reset_n) |-> low_q >= 6'(lhc_pkg::RESET_PULSE_CNT))
    else $error("hardware reset pulse too short");
endmodule

/* lhc_device.sv */
// LCD device end: command decoder, host port and display RAM
//
// Contract
// RQ1 - Select high stores RAM, low decodes command
// RQ2 - Hardware reset pulse restores initial state
// RQ3 - 6800: read/write high selects a read
// RQ4 - 6800: read/write low selects a write
// RQ5 - 6800: latch while enable high, select low
// RQ6 - First RAM read after setup is dummy
// RQ7 - 8080: strobes act only with select low
// RQ8 - 8080: select line picks RAM or status
// RQ9 - Serial shifts eight bits MSB first, rising
// RQ10 - 4-wire: select sampled on eighth clock
// RQ11 - Serial byte completes on its eighth bit
// RQ12 - 3-wire: length command routes N data bytes
// RQ13 - 3-wire: byte after count is command
// RQ14 - Host resets to recover serial sync
// RQ15 - Parallel reads and wide writes; serial writes only
// RQ16 - RAM holds 128 x 176 x 2 bits
// RQ17 - Undisplayed RAM rows stay accessible
// RQ18 - Three select pins choose the port
// RQ19 - Transfers accepted only with chip select
// RQ20 - Serial data bit 7, clock bit 6
// RQ21 - Hardware reset clears serial counters
`timescale 1ns/1ps
module lhc_device #(
  parameter int COLS  = lhc_pkg::RAM_COLS,
  parameter int PAGES = lhc_pkg::RAM_PAGES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Link
  lhc_link_if.dev          link,
  // Display side
  input  wire logic [12:0] disp_addr,
  output logic [7:0]       disp_byte_q,
  output logic [7:0]       start_line_q,
  output logic [7:0]       offset_q,
  output logic [7:0]       mux_ratio_q,
  output logic [5:0]       page_q,
  output logic [6:0]       column_q
);
  logic [23:0] s1_q;
  logic [23:0] s2_q;
  logic [7:0]  ram_q [COLS*PAGES];
  logic [15:0] wdata_q;
  logic        wdc_q;
  logic        wr_prev_q;
  logic        rd_prev_q;
  logic        sck_prev_q;
  logic        hi_pend_q;
  logic [7:0]  hi_q;
  logic [6:0]  shift_q;
  logic [2:0]  bit_cnt_q;
  logic [8:0]  remain_q;
  logic [7:0]  rd_buf_q;
  logic [7:0]  dout_q;
  logic        oe_n_q;
  lhc_pkg::lhc_arg_t arg_q;
  logic        hw_rst_s;
  logic [2:0]  ps_s;
  logic        cs_s;
  logic        dc_s;
  logic        rw_s;
  logic        e_s;
  logic [15:0] d_s;
  logic        serial;
  logic        three_wire;
  logic        m6800;
  logic        wr_act;
  logic        rd_act;
  logic        wr_end;
  logic        rd_start;
  logic        sck_rise;
  logic        ser_done;
  logic        ev_v;
  logic        ev_dc;
  logic [7:0]  ev_b;
  logic        cmd_v;
  logic [12:0] idx;

  // Every pin is foreign to this clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= lhc_pkg::SYNC_RST;
      s2_q <= lhc_pkg::SYNC_RST;
    end else begin
      s1_q <= {link.hardware_reset_n, link.interface_select, link.cs_n,
               link.dc, link.rw_wr_n, link.e_rd_n, link.d};
      s2_q <= s1_q;
    end
  end

  assign {hw_rst_s, ps_s, cs_s, dc_s, rw_s, e_s, d_s} = s2_q;
  assign serial     = !ps_s[lhc_pkg::PS_PAR]; // RQ18
  assign three_wire = serial && !ps_s[lhc_pkg::PS_4W];
  assign m6800      = !serial && ps_s[lhc_pkg::PS_6800];
  // RQ5 RQ7 RQ19
  assign wr_act   = !serial && !cs_s && (m6800 ? (e_s && !rw_s) : !rw_s);
  assign rd_act   = !serial && !cs_s && (m6800 ? (e_s && rw_s) : !e_s);
  assign wr_end   = wr_prev_q && !wr_act;
  assign rd_start = rd_act && !rd_prev_q;
  // RQ9 RQ20
  assign sck_rise = serial && !cs_s && d_s[lhc_pkg::SCK_BIT] && !sck_prev_q;
  assign ser_done = sck_rise && (bit_cnt_q == 3'(lhc_pkg::BIT_LAST)); // RQ11
  assign idx      = {page_q, column_q};
  assign cmd_v    = ev_v && !ev_dc;

  // One byte event per cycle; the high half of a wide write follows
  always_comb begin
    ev_v  = 1'b0;
    ev_dc = 1'b0;
    ev_b  = 8'h00;
    if (hi_pend_q) begin
      ev_v  = 1'b1;
      ev_dc = 1'b1;
      ev_b  = hi_q;
    end else if (wr_end) begin
      ev_v  = 1'b1;
      ev_dc = wdc_q;
      ev_b  = wdata_q[7:0];
    end else if (ser_done) begin
      ev_v  = 1'b1;
      ev_dc = three_wire ? (remain_q != 9'h000) : dc_s; // RQ10 RQ12 RQ13
      ev_b  = {shift_q, d_s[lhc_pkg::SDA_BIT]};
    end
  end

  // Parallel strobe tracking and write capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_prev_q  <= 1'b0;
      rd_prev_q  <= 1'b0;
      sck_prev_q <= 1'b0;
      wdata_q    <= 16'h0000;
      wdc_q      <= 1'b0;
      hi_pend_q  <= 1'b0;
      hi_q       <= 8'h00;
    end else if (!hw_rst_s) begin
      wr_prev_q  <= 1'b0; // RQ2
      rd_prev_q  <= 1'b0;
      sck_prev_q <= 1'b0;
      hi_pend_q  <= 1'b0;
    end else begin
      wr_prev_q  <= wr_act;
      rd_prev_q  <= rd_act;
      sck_prev_q <= d_s[lhc_pkg::SCK_BIT];
      if (wr_act) begin
        wdata_q <= d_s;
        wdc_q   <= dc_s;
      end
      // Wide writes fill two columns, low byte first
      hi_pend_q <= wr_end && wdc_q && ps_s[lhc_pkg::PS_WIDE]; // RQ15
      hi_q      <= wdata_q[15:8];
    end
  end

  // Serial shifter; no resync on select, only hardware reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q   <= 7'h00;
      bit_cnt_q <= 3'h0;
    end else if (!hw_rst_s) begin
      shift_q   <= 7'h00; // RQ21 RQ14
      bit_cnt_q <= 3'h0;
    end else if (sck_rise) begin
      shift_q   <= {shift_q[5:0], d_s[lhc_pkg::SDA_BIT]}; // RQ9
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  // Command decoder and registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arg_q        <= lhc_pkg::LHC_ARG_NONE;
      start_line_q <= lhc_pkg::START_RST;
      offset_q     <= lhc_pkg::OFFSET_RST;
      mux_ratio_q  <= lhc_pkg::MUX_RST;
      remain_q     <= 9'h000;
    end else if (!hw_rst_s) begin
      arg_q        <= lhc_pkg::LHC_ARG_NONE; // RQ2 RQ21
      start_line_q <= lhc_pkg::START_RST;
      offset_q     <= lhc_pkg::OFFSET_RST;
      mux_ratio_q  <= lhc_pkg::MUX_RST;
      remain_q     <= 9'h000;
    end else begin
      if (ser_done && three_wire && remain_q != 9'h000) begin
        remain_q <= remain_q - 9'h001; // RQ12 RQ13
      end
      if (cmd_v) begin // RQ1
        arg_q <= lhc_pkg::LHC_ARG_NONE;
        case (arg_q)
          lhc_pkg::LHC_ARG_START:  start_line_q <= ev_b;
          lhc_pkg::LHC_ARG_OFFSET: offset_q     <= ev_b;
          lhc_pkg::LHC_ARG_MUX:    mux_ratio_q  <= ev_b;
          lhc_pkg::LHC_ARG_LEN:    remain_q     <= {1'b0, ev_b} + 9'h001; // RQ12
          lhc_pkg::LHC_ARG_PAGE:   arg_q        <= lhc_pkg::LHC_ARG_NONE;
          default: begin
            if ((ev_b & 8'hfc) == lhc_pkg::CMD_START) begin
              arg_q <= lhc_pkg::LHC_ARG_START;
            end else if ((ev_b & 8'hfc) == lhc_pkg::CMD_OFFSET) begin
              arg_q <= lhc_pkg::LHC_ARG_OFFSET;
            end else if ((ev_b & 8'hfc) == lhc_pkg::CMD_MUX) begin
              arg_q <= lhc_pkg::LHC_ARG_MUX;
            end else if (ev_b == lhc_pkg::CMD_PAGE) begin
              arg_q <= lhc_pkg::LHC_ARG_PAGE;
            end else if (ev_b == lhc_pkg::CMD_DATA_LEN) begin
              arg_q <= lhc_pkg::LHC_ARG_LEN;
            end
          end
        endcase
      end
    end
  end

  // Address pointer; every RAM access steps the column
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      page_q   <= 6'h00;
      column_q <= 7'h00;
    end else if (!hw_rst_s) begin
      page_q   <= 6'h00; // RQ2
      column_q <= 7'h00;
    end else if ((ev_v && ev_dc) || (rd_start && dc_s)) begin
      column_q <= column_q + 7'h01;
    end else if (cmd_v && arg_q == lhc_pkg::LHC_ARG_PAGE) begin
      // Any of the 44 pages, shown or not, may be addressed
      if (ev_b < 8'(PAGES)) begin
        page_q <= ev_b[5:0]; // RQ17
      end
    end else if (cmd_v && arg_q == lhc_pkg::LHC_ARG_NONE) begin
      if ((ev_b & 8'hf0) == lhc_pkg::CMD_COL_LO) begin
        column_q[3:0] <= ev_b[3:0];
      end else if ((ev_b & 8'hf8) == lhc_pkg::CMD_COL_HI) begin
        column_q[6:4] <= ev_b[2:0];
      end
    end
  end

  // Display RAM: contents survive reset
  always_ff @(posedge clk) begin
    if (ev_v && ev_dc) begin
      ram_q[idx] <= ev_b; // RQ1 RQ16
    end
    disp_byte_q <= ram_q[disp_addr];
  end

  // Read port: RAM reads come through a one-deep pipeline
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_buf_q <= 8'h00;
      dout_q   <= 8'h00;
      oe_n_q   <= 1'b1;
    end else if (!hw_rst_s) begin
      oe_n_q <= 1'b1; // RQ2
    end else begin
      if (rd_start) begin
        oe_n_q <= 1'b0; // RQ3 RQ7
        if (dc_s) begin
          dout_q   <= rd_buf_q; // RQ6 RQ8
          rd_buf_q <= ram_q[idx];
        end else begin
          dout_q <= {arg_q != lhc_pkg::LHC_ARG_NONE, remain_q != 9'h000,
                     lhc_pkg::STATUS_FILL[2:0], ps_s};
        end
      end else if (!rd_act) begin
        oe_n_q <= 1'b1;
      end
    end
  end

  assign link.dv_d      = dout_q;
  assign link.dv_d_oe_n = oe_n_q;
endmodule

/* lhc_host.sv */
// Host controller end: issues parallel or serial transfers and reset pulses
`timescale 1ns/1ps
module lhc_host (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Link
  lhc_link_if.hst          link,
  // User request side
  input  wire logic [2:0]  mode,
  input  wire logic        reset_req,
  input  wire logic        req_valid,
  input  wire logic        req_read,
  input  wire logic        req_dc,
  input  wire logic [15:0] req_data,
  output logic             req_ready_q,
  output logic             rd_valid_q,
  output logic [7:0]       rd_data_q
);
  lhc_pkg::lhc_hstate_t st_q;
  logic [5:0]  cnt_q;
  logic [2:0]  bit_q;
  logic [2:0]  mode_q;
  logic        rd_q;
  logic        dc_q;
  logic [15:0] dat_q;
  logic [7:0]  din1_q;
  logic [7:0]  din2_q;
  logic        cs_n_q;
  logic        rst_pin_q;
  logic        e_q;
  logic        rw_q;
  logic        dcp_q;
  logic [15:0] hd_q;
  logic        hoe_n_q;
  logic        serial;
  logic        m6800;
  logic        cnt_end;
  logic        req_ser;

  assign serial  = !mode_q[lhc_pkg::PS_PAR];
  assign m6800   = mode_q[lhc_pkg::PS_6800] && !serial;
  assign cnt_end = (cnt_q == 6'h01);
  // Decide with the mode taken at this edge, not the copy from before it
  assign req_ser = !mode[lhc_pkg::PS_PAR];

  // Read data crosses from the device end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      din1_q <= 8'h00;
      din2_q <= 8'h00;
    end else begin
      din1_q <= link.d[7:0];
      din2_q <= din1_q;
    end
  end

  // Sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q        <= lhc_pkg::LHC_H_IDLE;
      cnt_q       <= 6'h00;
      bit_q       <= 3'h0;
      mode_q      <= 3'h0;
      rd_q        <= 1'b0;
      dc_q        <= 1'b0;
      dat_q       <= 16'h0000;
      req_ready_q <= 1'b0;
      rd_valid_q  <= 1'b0;
      rd_data_q   <= 8'h00;
    end else begin
      rd_valid_q <= 1'b0;
      if (st_q != lhc_pkg::LHC_H_IDLE) begin
        cnt_q <= cnt_q - 6'h01;
      end
      case (st_q)
        lhc_pkg::LHC_H_IDLE: begin
          mode_q      <= mode;
          req_ready_q <= !reset_req;
          if (reset_req) begin
            st_q  <= lhc_pkg::LHC_H_RST; // RQ2 RQ14
            // Pulse plus recovery overflows five bits, so add at six
            cnt_q <= 6'(lhc_pkg::RESET_PULSE_CNT) +
                     6'(lhc_pkg::RESET_RECOVER_CNT);
          end else if (req_valid && req_ready_q) begin
            req_ready_q <= 1'b0;
            rd_q        <= req_read;
            dc_q        <= req_dc;
            dat_q       <= req_data;
            if (req_ser && req_read) begin
              // Serial ports are write only: answer zero at once
              rd_valid_q  <= 1'b1; // RQ15
              rd_data_q   <= 8'h00;
              req_ready_q <= 1'b1;
            end else if (req_ser) begin
              st_q  <= lhc_pkg::LHC_H_SER;
              bit_q <= 3'h0;
              cnt_q <= 6'(lhc_pkg::SCK_HALF_CNT) +
                       6'(lhc_pkg::SCK_HALF_CNT);
            end else begin
              st_q  <= lhc_pkg::LHC_H_SETUP;
              cnt_q <= 6'(lhc_pkg::SETUP_CNT);
            end
          end
        end
        lhc_pkg::LHC_H_RST, lhc_pkg::LHC_H_HOLD: begin
          if (cnt_end) begin
            st_q <= lhc_pkg::LHC_H_IDLE;
          end
        end
        lhc_pkg::LHC_H_SETUP: begin
          if (cnt_end) begin
            st_q  <= lhc_pkg::LHC_H_STROBE;
            cnt_q <= 6'(lhc_pkg::STROBE_CNT);
          end
        end
        lhc_pkg::LHC_H_STROBE: begin
          if (cnt_end) begin
            st_q  <= lhc_pkg::LHC_H_HOLD;
            cnt_q <= 6'(lhc_pkg::HOLD_CNT);
            if (rd_q) begin
              rd_valid_q <= 1'b1;
              rd_data_q  <= din2_q;
            end
          end
        end
        lhc_pkg::LHC_H_SER: begin
          if (cnt_end) begin
            bit_q <= bit_q + 3'h1;
            cnt_q <= 6'(lhc_pkg::SCK_HALF_CNT) +
                     6'(lhc_pkg::SCK_HALF_CNT);
            if (bit_q == 3'(lhc_pkg::BIT_LAST)) begin
              st_q  <= lhc_pkg::LHC_H_HOLD; // RQ11
              cnt_q <= 6'(lhc_pkg::HOLD_CNT);
            end
          end
        end
        default: st_q <= lhc_pkg::LHC_H_IDLE;
      endcase
    end
  end

  // Pin drivers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_n_q    <= 1'b1;
      rst_pin_q <= 1'b1;
      e_q       <= 1'b0;
      rw_q      <= 1'b1;
      dcp_q     <= 1'b0;
      hd_q      <= 16'h0000;
      hoe_n_q   <= 1'b1;
    end else begin
      rst_pin_q <= !(st_q == lhc_pkg::LHC_H_RST &&
                     cnt_q > 6'(lhc_pkg::RESET_RECOVER_CNT)); // RQ2
      cs_n_q  <= (st_q == lhc_pkg::LHC_H_IDLE ||
                  st_q == lhc_pkg::LHC_H_RST); // RQ19
      dcp_q   <= serial && !mode_q[lhc_pkg::PS_4W] ? 1'b0 : dc_q;
      hoe_n_q <= 1'b1;
      hd_q    <= 16'h0000;
      rw_q    <= 1'b1;
      e_q     <= !m6800;
      if (st_q == lhc_pkg::LHC_H_SER) begin
        hoe_n_q <= 1'b0; // RQ20
        hd_q[lhc_pkg::SDA_BIT] <= dat_q[3'h7 - bit_q]; // RQ9
        hd_q[lhc_pkg::SCK_BIT] <= (cnt_q <= 6'(lhc_pkg::SCK_HALF_CNT));
      // Serial hold releases the bus, which reads low: parallel data there would move SDA
      // under a high clock and could fake an extra clock edge
      end else if (!serial && (st_q == lhc_pkg::LHC_H_SETUP ||
                               st_q == lhc_pkg::LHC_H_STROBE ||
                               st_q == lhc_pkg::LHC_H_HOLD)) begin
        hoe_n_q <= rd_q;
        hd_q    <= dat_q;
        if (m6800) begin
          rw_q <= rd_q; // RQ3 RQ4
          e_q  <= (st_q == lhc_pkg::LHC_H_STROBE); // RQ5
        end else begin
          rw_q <= !(st_q == lhc_pkg::LHC_H_STROBE && !rd_q); // RQ7
          e_q  <= !(st_q == lhc_pkg::LHC_H_STROBE && rd_q);
        end
      end
    end
  end

  assign link.cs_n             = cs_n_q;
  assign link.dc               = dcp_q;
  assign link.rw_wr_n          = rw_q;
  assign link.e_rd_n           = e_q;
  assign link.hardware_reset_n = rst_pin_q;
  assign link.interface_select = mode_q; // RQ18
  assign link.h_d              = hd_q;
  assign link.h_d_oe_n         = hoe_n_q;
endmodule

/* lhc_link_if.sv */
// Pin bundle between host controller and LCD device end
`timescale 1ns/1ps
interface lhc_link_if;
  logic        cs_n;
  logic        dc;
  logic        rw_wr_n;
  logic        e_rd_n;
  logic        hardware_reset_n;
  logic [2:0]  interface_select;
  logic [15:0] h_d;
  logic        h_d_oe_n;
  logic [7:0]  dv_d;
  logic        dv_d_oe_n;
  logic [15:0] d;

  // Bus level; nobody driving reads as ground, like tied pins
  assign d[7:0]  = !dv_d_oe_n ? dv_d :
                   (!h_d_oe_n ? h_d[7:0] : 8'h00);
  assign d[15:8] = !h_d_oe_n ? h_d[15:8] : 8'h00;

  modport dev (
    input  cs_n, dc, rw_wr_n, e_rd_n, hardware_reset_n, interface_select, d,
    output dv_d, dv_d_oe_n
  );
  modport hst (
    input  d,
    output cs_n, dc, rw_wr_n, e_rd_n, hardware_reset_n, interface_select,
           h_d, h_d_oe_n
  );
endinterface

/* lhc_pkg.sv */
// Shared constants and types for the LCD host command link
package lhc_pkg;
  // Timing
  localparam int CLK_NS          = 40;
  localparam int RESET_PULSE_NS  = 1000;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] RESET_PULSE_CNT  = 5'(RESET_PULSE_CYC);
  localparam logic [4:0] RESET_RECOVER_CNT = 5'h08;
  localparam logic [4:0] SETUP_CNT  = 5'h04;
  localparam logic [4:0] STROBE_CNT = 5'h08;
  localparam logic [4:0] HOLD_CNT   = 5'h04;
  localparam logic [4:0] SCK_HALF_CNT = 5'h04;
  // Display RAM geometry: 128 columns, 176 rows of 2 bits, 4 rows a byte
  localparam int RAM_COLS  = 128;
  localparam int RAM_PAGES = 44;
  localparam int RAM_BYTES = RAM_COLS * RAM_PAGES;
  localparam int IDX_W     = 13;
  // Interface select bit positions
  localparam int PS_PAR  = 0;
  localparam int PS_4W   = 1;
  localparam int PS_6800 = 1;
  localparam int PS_WIDE = 2;
  // Serial pins on the data bus
  localparam int SDA_BIT = 7;
  localparam int SCK_BIT = 6;
  localparam int BIT_LAST = 7;
  // Command codes
  localparam logic [7:0] CMD_COL_LO   = 8'h00;
  localparam logic [7:0] CMD_COL_HI   = 8'h10;
  localparam logic [7:0] CMD_START    = 8'h40;
  localparam logic [7:0] CMD_OFFSET   = 8'h44;
  localparam logic [7:0] CMD_MUX      = 8'h48;
  localparam logic [7:0] CMD_PAGE     = 8'hb0;
  localparam logic [7:0] CMD_DATA_LEN = 8'he8;
  // Reset values and status fill
  localparam logic [7:0] MUX_RST    = 8'ha0;
  localparam logic [7:0] START_RST  = 8'h00;
  localparam logic [7:0] OFFSET_RST = 8'h00;
  localparam logic [23:0] SYNC_RST  = 24'h880000;
  localparam logic [7:0] STATUS_FILL = 8'h00;
  // Second-byte targets of two-byte commands
  typedef enum logic [2:0] {
    LHC_ARG_NONE, LHC_ARG_START, LHC_ARG_OFFSET, LHC_ARG_MUX,
    LHC_ARG_PAGE, LHC_ARG_LEN
  } lhc_arg_t;
  typedef enum logic [2:0] {
    LHC_H_IDLE, LHC_H_RST, LHC_H_SETUP, LHC_H_STROBE, LHC_H_HOLD,
    LHC_H_SER
  } lhc_hstate_t;
endpackage

/* tb.sv */
// Self-checking bench: host and device ends joined by the link
`timescale 1ns/1ps
module tb;
  logic        clk;
  logic        rst_n;
  logic [2:0]  mode;
  logic        reset_req;
  logic        req_valid;
  logic        req_read;
  logic        req_dc;
  logic [15:0] req_data;
  logic        req_ready_q;
  logic        rd_valid_q;
  logic [7:0]  rd_data_q;
  logic [12:0] disp_addr;
  logic [7:0]  disp_byte_q;
  logic [7:0]  start_line_q;
  logic [7:0]  offset_q;
  logic [7:0]  mux_ratio_q;
  logic [5:0]  page_q;
  logic [6:0]  column_q;
  logic [7:0]  junk;
  int          bad_count;
  int          tests_run;

  lhc_link_if link ();
  lhc_host lhc_host_i (.clk(clk), .rst_n(rst_n), .link(link), .mode(mode),
    .reset_req(reset_req), .req_valid(req_valid), .req_read(req_read),
    .req_dc(req_dc), .req_data(req_data), .req_ready_q(req_ready_q),
    .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q));
  lhc_device lhc_device_i (.clk(clk), .rst_n(rst_n), .link(link),
    .disp_addr(disp_addr), .disp_byte_q(disp_byte_q),
    .start_line_q(start_line_q), .offset_q(offset_q),
    .mux_ratio_q(mux_ratio_q), .page_q(page_q), .column_q(column_q));
  lhc_checker lhc_checker_i (.clk(clk), .rst_n(rst_n), .cs_n(link.cs_n),
    .dc(link.dc), .rw_wr_n(link.rw_wr_n), .e_rd_n(link.e_rd_n),
    .hardware_reset_n(link.hardware_reset_n),
    .interface_select(link.interface_select), .h_d(link.h_d),
    .h_d_oe_n(link.h_d_oe_n), .dv_d(link.dv_d),
    .dv_d_oe_n(link.dv_d_oe_n), .d(link.d));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (req_ready_q !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 400) begin
        bad_count++;
        $display("BAD %0t host never ready", $time);
        final_report();
      end
    end
  endtask
  // Request is held from just after an edge until the edge that takes it
  task automatic xfer(input logic rd, input logic dcv, input logic [15:0] v);
    wait_ready();
    req_valid = 1'b1;
    req_read = rd;
    req_dc = dcv;
    req_data = v;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
  endtask
  // Device commits no later than the edge at which the host frees the bus
  task automatic wr(input logic dcv, input logic [15:0] v);
    xfer(1'b0, dcv, v);
    wait_ready();
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic rd_get(input logic dcv, output logic [7:0] q);
    int n;
    xfer(1'b1, dcv, 16'h0000);
    n = 0;
    while (rd_valid_q !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 40) begin
      bad_count++;
      $display("BAD %0t no read answer", $time);
      final_report();
    end
    q = rd_data_q;
    // Let an edge pass so the next request never shares this time step
    @(posedge clk);
    #1;
  endtask
  task automatic rd_chk(input logic dcv, input logic [7:0] exp);
    logic [7:0] q;
    rd_get(dcv, q);
    check(q, exp);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] arg);
    wr(1'b0, {8'h00, op});
    wr(1'b0, {8'h00, arg});
  endtask
  task automatic ram_chk(input logic [12:0] a, input logic [7:0] exp);
    disp_addr = a;
    repeat (2) @(posedge clk);
    #1;
    check(disp_byte_q, exp);
  endtask
  task automatic hw_reset();
    wait_ready();
    reset_req = 1'b1;
    @(posedge clk);
    #1;
    reset_req = 1'b0;
    @(posedge clk);
    #1;
    wait_ready();
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Overall limit so a stuck handshake still ends the run
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    mode = 3'h3;
    reset_req = 1'b0;
    req_valid = 1'b0;
    req_read = 1'b0;
    req_dc = 1'b0;
    req_data = 16'h0000;
    disp_addr = 13'h0000;
    bad_count = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    wait_ready();
    check(mux_ratio_q, 8'ha0);
    cmd(8'hb0, 8'h2b);
    cmd(8'h17, 8'h0f);
    check({2'h0, page_q}, 8'h2b);
    check({1'h0, column_q}, 8'h7f);
    wr(1'b1, 16'h003c);
    check({1'h0, column_q}, 8'h00);
    ram_chk({6'h2b, 7'h7f}, 8'h3c);
    cmd(8'h17, 8'h0f);
    rd_get(1'b1, junk);
    rd_chk(1'b1, 8'h3c);
    rd_chk(1'b0, 8'h03);
    mode = 3'h7;
    cmd(8'h11, 8'h00);
    wr(1'b1, 16'hbeef);
    ram_chk({6'h2b, 7'h10}, 8'hef);
    ram_chk({6'h2b, 7'h11}, 8'hbe);
    rd_chk(1'b0, 8'h07);
    mode = 3'h1;
    for (int i = 0; i < 3; i++) begin
      cmd(8'h40 + 8'(4 * i), 8'h11 + 8'(i));
    end
    check(start_line_q, 8'h11);
    check(offset_q, 8'h12);
    check(mux_ratio_q, 8'h13);
    cmd(8'h11, 8'h00);
    rd_get(1'b1, junk);
    rd_chk(1'b1, 8'hef);
    rd_chk(1'b1, 8'hbe);
    rd_chk(1'b0, 8'h01);
    mode = 3'h2;
    cmd(8'hb0, 8'h02);
    cmd(8'h10, 8'h03);
    wr(1'b1, 16'h001e);
    check({2'h0, page_q}, 8'h02);
    ram_chk({6'h02, 7'h03}, 8'h1e);
    rd_chk(1'b1, 8'h00);
    mode = 3'h0;
    cmd(8'hb0, 8'h01);
    cmd(8'h10, 8'h04);
    cmd(8'he8, 8'h01);
    cmd(8'h11, 8'h22);
    cmd(8'hb0, 8'h07);
    check({2'h0, page_q}, 8'h07);
    ram_chk({6'h01, 7'h04}, 8'h11);
    ram_chk({6'h01, 7'h05}, 8'h22);
    cmd(8'he8, 8'h02);
    wr(1'b0, 16'h0033);
    hw_reset();
    check({2'h0, page_q}, 8'h00);
    check({1'h0, column_q}, 8'h00);
    check(start_line_q, 8'h00);
    check(offset_q, 8'h00);
    check(mux_ratio_q, 8'ha0);
    cmd(8'hb0, 8'h09);
    check({2'h0, page_q}, 8'h09);
    final_report();
  end
endmodule
